// ### bench/black_level_loop_steering_bench.sv
// Self-checking testbench of the black-level loop steering block.
`timescale 1ns/1ps
module black_level_loop_steering_bench;
  logic                       clock_in     = 1'b0;
  logic                       rst_n_in     = 1'b0;
  logic [bls_pkg::ADDR_W-1:0] reg_addr_in  = 4'h0;
  logic [7:0]                 reg_wdata_in = 8'h00;
  logic                       reg_write_in = 1'b0;
  logic                       reg_read_in  = 1'b0;
  logic [7:0]                 reg_rdata_out;
  logic                       clamp_w, frame_w, area_w, ana_w, fil_w, hold_w, pulse_w;
  logic [7:0]                 rv;
  int                         mismatches = 0;
  int                         n_compared = 0;
  int                         na, nf, nh, np, t0, t1;
  logic [7:0] rst_v [5] = '{bls_pkg::CTRL_RST, bls_pkg::STEER_DELAY_RST, bls_pkg::PULSE_DELAY_RST,
                            bls_pkg::PULSE_WIDTH_RST, bls_pkg::GAIN_RST};
  // Routing table: control value, expected analog and filter high cycles for one line.
  logic [7:0] rt_c [6] = '{8'h20, 8'h22, 8'h26, 8'h24, 8'h00, 8'h04};
  logic [7:0] rt_a [6] = '{8'h08, 8'h00, 8'h00, 8'h08, 8'h04, 8'h04};
  logic [7:0] rt_f [6] = '{8'h00, 8'h08, 8'h00, 8'h00, 8'h08, 8'h00};
  // Area table: usage field in the control value, expected {analog, filter, hold} with area high.
  logic [7:0] ar_c [4] = '{8'h00, 8'h08, 8'h10, 8'h18};
  logic [7:0] ar_e [4] = '{8'h00, 8'h01, 8'h04, 8'h03};

  // Pixel clock at 125 MHz.
  always #4 clock_in = ~clock_in;

  bls_timing_gen tgen (.clock_in(clock_in), .clamp_pin_out(clamp_w), .frame_sync_out(frame_w), .area_out(area_w));

  bls_steering #(.DATA_W(8)) dut (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
    .external_clamp_enable_pin_in(clamp_w), .frame_sync_pin_in(frame_w), .area_define_in(area_w),
    .analog_loop_enable_out(ana_w), .filter_enable_out(fil_w), .error_hold_enable_out(hold_w),
    .internal_clamp_window_pulse_out(pulse_w));

  // Shared comparison; case inequality keeps an unknown from passing.
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_in);
    reg_write_in <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge clock_in);
    reg_write_in <= 1'b0;
  endtask

  // One-cycle read strobe; the data is taken in the following cycle only.
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock_in);
    reg_read_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clock_in);
    reg_read_in <= 1'b0;
    @(negedge clock_in);
    d = reg_rdata_out;
  endtask

  // One line from the timing model; counts enable cycles and notes where the pulse copy starts.
  task automatic run_line();
    na = 0;
    nf = 0;
    nh = 0;
    np = 0;
    t0 = -1;
    fork
      tgen.clamp_line();
    join_none
    for (int i = 0; i < 44; i++) begin
      @(negedge clock_in);
      na += (ana_w === 1'b1);
      nf += (fil_w === 1'b1);
      nh += (hold_w === 1'b1);
      np += (pulse_w === 1'b1);
      if (pulse_w === 1'b1 && t0 < 0) t0 = i;
    end
  endtask

  // Counts, then the verdict; every way out of the run comes through here.
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Watchdog: the tests need roughly 7 us, so 100 us means a hang.
  initial begin
    #100000;
    mismatches++;
    print_verdict();
  end

  // Main sequence.
  initial begin
    repeat (8) @(posedge clock_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(4'(i), rv);
      check(rv, rst_v[i]);
    end
    rd(4'hF, rv);
    check(rv, 8'h00);
    wr(bls_pkg::ADDR_STATUS, 8'hFF);
    rd(bls_pkg::ADDR_STATUS, rv);
    check({7'h00, rv[bls_pkg::STAT_PENDING_BIT]}, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wr(bls_pkg::ADDR_CTRL, rt_c[i]);
      run_line();
      check(8'(na), rt_a[i]);
      check(8'(nf), rt_f[i]);
      check(8'(nh), rt_f[i]);
    end
    // Update only after a gain write; the pending mark clears once a pulse was delivered.
    wr(bls_pkg::ADDR_CTRL, 8'h21);
    run_line();
    check(8'(na), 8'h00);
    check(8'(nf), 8'h08);
    wr(bls_pkg::ADDR_GAIN, 8'h5A);
    rd(bls_pkg::ADDR_GAIN, rv);
    check(rv, 8'h5A);
    rd(bls_pkg::ADDR_STATUS, rv);
    check({7'h00, rv[bls_pkg::STAT_PENDING_BIT]}, 8'h01);
    run_line();
    check(8'(na), 8'h08);
    rd(bls_pkg::ADDR_STATUS, rv);
    check({7'h00, rv[bls_pkg::STAT_PENDING_BIT]}, 8'h00);
    run_line();
    check(8'(na), 8'h00);
    // Start delay of two pulses, restarted by each frame.
    wr(bls_pkg::ADDR_STEER_DELAY, 8'h02);
    wr(bls_pkg::ADDR_CTRL, 8'h20);
    tgen.frame_start();
    repeat (6) @(posedge clock_in);
    for (int i = 0; i < 3; i++) begin
      run_line();
      check(8'(na), (i >= 2) ? 8'h08 : 8'h00);
    end
    tgen.frame_start();
    repeat (6) @(posedge clock_in);
    run_line();
    check(8'(na), 8'h00);
    check(8'(nf), 8'h08);
    wr(bls_pkg::ADDR_STEER_DELAY, 8'h00);
    // Pixel delay moves the pulse start by the programmed difference; width sets its length.
    run_line();
    t1 = t0;
    wr(bls_pkg::ADDR_PULSE_DELAY, 8'h09);
    run_line();
    check(8'(t0 - t1), 8'h05);
    check(8'(np), 8'h08);
    wr(bls_pkg::ADDR_PULSE_WIDTH, 8'h03);
    run_line();
    check(8'(np), 8'h03);
    // Area define held high under each usage setting.
    tgen.set_area(1'b1);
    run_line();
    check(8'(na), 8'h03);
    check(8'(nh), 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(bls_pkg::ADDR_CTRL, ar_c[i]);
      repeat (5) @(posedge clock_in);
      @(negedge clock_in);
      check({5'h00, ana_w, fil_w, hold_w}, ar_e[i]);
    end
    tgen.set_area(1'b0);
    print_verdict();
  end
endmodule

// ### bench/bls_checker.sv
// Port-level assertions of the black-level loop steering block.
`timescale 1ns/1ps
module bls_checker #(
  parameter int DATA_W = 8
) (
  input wire logic                       clock_in,
  input wire logic                       rst_n_in,
  input wire logic [bls_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0]          reg_wdata_in,
  input wire logic                       reg_write_in,
  input wire logic                       reg_read_in,
  input wire logic [DATA_W-1:0]          reg_rdata_out,
  input wire logic                       external_clamp_enable_pin_in,
  input wire logic                       frame_sync_pin_in,
  input wire logic                       area_define_in,
  input wire logic                       analog_loop_enable_out,
  input wire logic                       filter_enable_out,
  input wire logic                       error_hold_enable_out,
  input wire logic                       internal_clamp_window_pulse_out
);
  logic [7:0] ctrl_q;
  logic [3:0] age_q;
  logic [1:0] use_w;
  logic       ok_w;

  // Shadow of the control register; age_q keeps checks quiet while a new setting ripples through.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      ctrl_q <= 8'h00;
      age_q  <= 4'h0;
    end else if (reg_write_in && reg_addr_in == bls_pkg::ADDR_CTRL) begin
      ctrl_q <= reg_wdata_in[7:0];
      age_q  <= 4'h0;
    end else if (age_q != 4'hF) begin
      age_q <= age_q + 4'h1;
    end
  end

  // Decoded settings used by the properties.
  assign use_w = ctrl_q[4:3];
  assign ok_w  = age_q > 4'h4;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  // Steering relations between the enables, the pulse copy and the pins.
  AST_EXT_SOURCE: assert property (ok_w && !ctrl_q[5] && use_w != 2'h2 |->
    analog_loop_enable_out == $past(external_clamp_enable_pin_in, 3)) else $error("analog enable not pin copy");
  AST_ANA_BLOCKED: assert property (ok_w && ctrl_q[5] && ctrl_q[1] && use_w != 2'h2 |->
    !analog_loop_enable_out) else $error("blocked pulse reached analog loop");
  AST_FIL_BLOCKED: assert property (ok_w && ctrl_q[2] && use_w != 2'h3 |-> !filter_enable_out)
    else $error("blocked pulse reached filter");
  AST_HOLD_FOLLOWS: assert property (ok_w && use_w != 2'h1 |-> error_hold_enable_out == filter_enable_out)
    else $error("hold enable differs from filter enable");
  AST_HOLD_AREA: assert property (ok_w && use_w == 2'h1 |-> error_hold_enable_out == $past(area_define_in))
    else $error("hold enable not area copy");
  AST_ANA_AREA: assert property (ok_w && use_w == 2'h2 && area_define_in |=> analog_loop_enable_out)
    else $error("area did not enable analog loop");
  AST_FIL_AREA: assert property (ok_w && use_w == 2'h3 && area_define_in |=> filter_enable_out)
    else $error("area did not enable filter");
  AST_ANA_FROM_PULSE: assert property (ok_w && ctrl_q[5] && use_w != 2'h2 && analog_loop_enable_out |->
    internal_clamp_window_pulse_out) else $error("analog enable without pulse");
  AST_FIL_FROM_PULSE: assert property (ok_w && use_w != 2'h3 && filter_enable_out |->
    internal_clamp_window_pulse_out) else $error("filter enable without pulse");
  AST_ONE_ROUTE: assert property (ok_w && ctrl_q[5] && !ctrl_q[2] && use_w == 2'h0 &&
    internal_clamp_window_pulse_out |-> analog_loop_enable_out != filter_enable_out) else $error("pulse not routed once");
endmodule

bind bls_steering bls_checker #(.DATA_W(DATA_W)) u_chk (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
  .external_clamp_enable_pin_in(external_clamp_enable_pin_in), .frame_sync_pin_in(frame_sync_pin_in),
  .area_define_in(area_define_in), .analog_loop_enable_out(analog_loop_enable_out),
  .filter_enable_out(filter_enable_out), .error_hold_enable_out(error_hold_enable_out),
  .internal_clamp_window_pulse_out(internal_clamp_window_pulse_out));

// ### bench/bls_timing_gen.sv
// Model of the CCD timing and area generators that feed the steering block's pins.
`timescale 1ns/1ps
module bls_timing_gen (
  input  wire logic clock_in,
  output logic      clamp_pin_out,
  output logic      frame_sync_out,
  output logic      area_out
);
  // Pins idle low; a clamp window is a short high level whose fall times the internal pulse.
  initial begin
    clamp_pin_out  = 1'b0;
    frame_sync_out = 1'b0;
    area_out       = 1'b0;
  end

  // One line: the clamp pin is high for four pixels, then falls.
  task automatic clamp_line();
    @(posedge clock_in);
    clamp_pin_out <= 1'b1;
    repeat (4) @(posedge clock_in);
    clamp_pin_out <= 1'b0;
  endtask

  // Frame start: held for three pixels so the synchroniser surely sees the rise.
  task automatic frame_start();
    @(posedge clock_in);
    frame_sync_out <= 1'b1;
    repeat (3) @(posedge clock_in);
    frame_sync_out <= 1'b0;
  endtask

  // The area-define level changes right after an edge.
  task automatic set_area(input logic v);
    @(posedge clock_in);
    area_out <= v;
  endtask
endmodule

// ### core/bls_clamp_pulse_gen.sv
// Internal clamp-window pulse generator timed from the external clamp pin.
`timescale 1ns/1ps
module bls_clamp_pulse_gen #(
  parameter int CNT_W = 8
) (
  input  wire logic             clock_in,
  input  wire logic             rst_n_in,
  input  wire logic             clamp_sync_in,
  input  wire logic [CNT_W-1:0] pulse_delay_in,
  input  wire logic [CNT_W-1:0] pulse_width_in,
  output logic                  pulse_out
);

  // The counter must at least tell one pixel from the next.
  if (CNT_W < 2) begin : g_cnt_check
    $error("bls_clamp_pulse_gen needs CNT_W of at least two.");
  end

  typedef struct packed {
    bls_pkg::bls_pg_state_t state;
    logic [CNT_W-1:0]       cnt;
    logic                   prev;
    logic                   pulse;
  } bls_pg_t;

  bls_pg_t st_d;
  bls_pg_t st_q;
  logic    fall;

  // A falling clamp edge restarts the delay, even in the middle of a pulse.
  always_comb begin
    st_d      = st_q;
    fall      = st_q.prev & ~clamp_sync_in;
    st_d.prev = clamp_sync_in;
    unique case (st_q.state)
      bls_pkg::PG_IDLE: begin
      end
      bls_pkg::PG_DELAY: begin
        if (st_q.cnt >= pulse_delay_in) begin
          st_d.state = (pulse_width_in != '0) ? bls_pkg::PG_PULSE : bls_pkg::PG_IDLE; // [RULE13]
          st_d.cnt   = CNT_W'(1);
        end else begin
          st_d.cnt = st_q.cnt + CNT_W'(1);
        end
      end
      bls_pkg::PG_PULSE: begin
        if (st_q.cnt >= pulse_width_in) begin
          st_d.state = bls_pkg::PG_IDLE;
        end else begin
          st_d.cnt = st_q.cnt + CNT_W'(1);
        end
      end
      default: begin
        st_d.state = bls_pkg::PG_IDLE;
      end
    endcase
    if (fall) begin
      st_d.state = bls_pkg::PG_DELAY; // [RULE13]
      st_d.cnt   = CNT_W'(1);
    end
    st_d.pulse = (st_d.state == bls_pkg::PG_PULSE);
  end

  // Synchronous active-low reset parks the generator idle.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      st_q <= '{state: bls_pkg::PG_IDLE, cnt: '0, prev: 1'b0, pulse: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign pulse_out = st_q.pulse;

endmodule

// ### core/bls_pkg.sv
// Shared constants and types of the black-level loop steering block.
package bls_pkg;

  // Register port geometry.
  localparam int ADDR_W = 4;
  localparam int REG_W  = 8;

  // Register indices on the plain register port.
  localparam logic [ADDR_W-1:0] ADDR_CTRL        = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_STEER_DELAY = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_PULSE_DELAY = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_PULSE_WIDTH = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_GAIN        = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_STATUS      = 4'h5;

  // Bit positions inside the control register.
  localparam int CTRL_UPD_BIT     = 0;
  localparam int CTRL_BLK_ANA_BIT = 1;
  localparam int CTRL_BLK_FIL_BIT = 2;
  localparam int CTRL_AREA_LSB    = 3;
  localparam int CTRL_AREA_MSB    = 4;
  localparam int CTRL_SEL_INT_BIT = 5;

  // Bit positions inside the status register.
  localparam int STAT_PENDING_BIT = 0;
  localparam int STAT_STEER_BIT   = 1;
  localparam int STAT_PULSE_BIT   = 2;
  localparam int STAT_ANALOG_BIT  = 3;
  localparam int STAT_FILTER_BIT  = 4;
  localparam int STAT_HOLD_BIT    = 5;

  // Values after reset.
  localparam logic [REG_W-1:0] CTRL_RST        = 8'h00;
  localparam logic [REG_W-1:0] STEER_DELAY_RST = 8'h00;
  localparam logic [REG_W-1:0] PULSE_DELAY_RST = 8'h04;
  localparam logic [REG_W-1:0] PULSE_WIDTH_RST = 8'h08;
  localparam logic [REG_W-1:0] GAIN_RST        = 8'h00;

  // Ways in which the area-define signal is combined.
  typedef enum logic [1:0] {
    AREA_OFF    = 2'h0,
    AREA_HOLD   = 2'h1,
    AREA_ANALOG = 2'h2,
    AREA_FILTER = 2'h3
  } bls_area_t;

  // Clamp pulse generator states, Gray coded along idle, delay, pulse.
  typedef enum logic [1:0] {
    PG_IDLE  = 2'h0,
    PG_DELAY = 2'h1,
    PG_PULSE = 2'h3
  } bls_pg_state_t;

endpackage

// ### core/bls_steering.sv
// Black-level loop steering: routes the clamp window to the analogue loop or the IIR filter.
//
// Behaviour
// [RULE1] Update option clear: internal clamp pulse reaches the analogue loop every frame.
// [RULE2] Update option set: internal pulse reaches the analogue loop only after a gain write.
// [RULE3] Analogue block bit clear: internal pulse may be steered to the analogue loop.
// [RULE4] Analogue block bit set: internal pulse never reaches the loop, goes to filter.
// [RULE5] Filter block bit clear: internal pulse may be steered to the IIR filter enable.
// [RULE6] Filter block bit set: internal pulse never reaches the IIR filter enable.
// [RULE7] Area usage 00: area-define signal is ignored completely.
// [RULE8] Area usage 01: area-define signal enables the IIR error-holding register.
// [RULE9] Area usage not 01: error-holding register follows the IIR filter enable.
// [RULE10] Area usage 10: area-define ORed with steered pulse into analogue loop enable.
// [RULE11] Area usage 11: area-define ORed with steered pulse into IIR filter enable.
// [RULE12] Source select picks external clamp pin or internal pulse for the analogue loop.
// [RULE13] Internal pulse starts a programmed pixel count after the clamp pin falls.
// [RULE14] Steering to the analogue loop waits a programmed count of internal pulses.
// [RULE15] Pending gain write clears once the next pulse was delivered to the analogue loop.
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/1ps
module bls_steering #(
  parameter int DATA_W = 8
) (
  input  wire logic                      clock_in,
  input  wire logic                      rst_n_in,
  input  wire logic [bls_pkg::ADDR_W-1:0] reg_addr_in,
  input  wire logic [DATA_W-1:0]         reg_wdata_in,
  input  wire logic                      reg_write_in,
  input  wire logic                      reg_read_in,
  output logic      [DATA_W-1:0]         reg_rdata_out,
  input  wire logic                      external_clamp_enable_pin_in,
  input  wire logic                      frame_sync_pin_in,
  input  wire logic                      area_define_in,
  output logic                           analog_loop_enable_out,
  output logic                           filter_enable_out,
  output logic                           error_hold_enable_out,
  output logic                           internal_clamp_window_pulse_out
);

  localparam int RW = bls_pkg::REG_W;

  // Narrower data would truncate the control and delay registers.
  if (DATA_W < RW) begin : g_data_check
    $error("bls_steering needs DATA_W of at least eight.");
  end

  // Whole state of the steering block, registered in one place.
  typedef struct packed {
    logic                loop_update_on_gain_write;
    logic                block_analog_steer;
    logic                block_filter_steer;
    bls_pkg::bls_area_t  area_define_usage;
    logic                select_internal_clamp_source;
    logic [RW-1:0]       analog_steer_start_delay;
    logic [RW-1:0]       clamp_pulse_pixel_delay;
    logic [RW-1:0]       clamp_pulse_width;
    logic [RW-1:0]       gain;
    logic                gain_write_pending;
    logic [RW-1:0]       pulse_cnt;
    logic                pulse_prev;
    logic                frame_prev;
    logic                take;
    logic                pulse_copy;
    logic                analog_en;
    logic                filter_en;
    logic                hold_en;
    logic [DATA_W-1:0]   rdata;
  } bls_top_state_t;

  bls_top_state_t st_d;
  bls_top_state_t st_q;

  // Synchronised pin levels and the generated pulse.
  logic [1:0]     pins_sync;
  logic           ext_clamp_s;
  logic           frame_s;
  logic           pulse;

  // Combinational helpers of the steering decision.
  logic           frame_rise;
  logic           pulse_fall;
  logic           steer_ok;
  logic           eligible;
  logic           take_now;
  logic           area_analog;
  logic           area_filter;
  logic           filter_now;

  // Area-define term of one usage mode; it is zero in every other mode.
  function automatic logic area_term(input bls_pkg::bls_area_t usage,
                                     input bls_pkg::bls_area_t mode,
                                     input logic               area);
    area_term = (usage == mode) & area;
  endfunction

  // Read multiplexer; unmapped indices read as zero.
  function automatic logic [RW-1:0] read_mux(input logic [bls_pkg::ADDR_W-1:0] addr,
                                             input bls_top_state_t             s,
                                             input logic                       ok);
    logic [RW-1:0] v;
    v = '0;
    unique case (addr)
      bls_pkg::ADDR_CTRL: begin
        v[bls_pkg::CTRL_UPD_BIT]                        = s.loop_update_on_gain_write;
        v[bls_pkg::CTRL_BLK_ANA_BIT]                    = s.block_analog_steer;
        v[bls_pkg::CTRL_BLK_FIL_BIT]                    = s.block_filter_steer;
        v[bls_pkg::CTRL_AREA_MSB:bls_pkg::CTRL_AREA_LSB] = s.area_define_usage;
        v[bls_pkg::CTRL_SEL_INT_BIT]                    = s.select_internal_clamp_source;
      end
      bls_pkg::ADDR_STEER_DELAY: begin
        v = s.analog_steer_start_delay;
      end
      bls_pkg::ADDR_PULSE_DELAY: begin
        v = s.clamp_pulse_pixel_delay;
      end
      bls_pkg::ADDR_PULSE_WIDTH: begin
        v = s.clamp_pulse_width;
      end
      bls_pkg::ADDR_GAIN: begin
        v = s.gain;
      end
      bls_pkg::ADDR_STATUS: begin
        v[bls_pkg::STAT_PENDING_BIT] = s.gain_write_pending;
        v[bls_pkg::STAT_STEER_BIT]   = ok;
        v[bls_pkg::STAT_PULSE_BIT]   = s.pulse_copy;
        v[bls_pkg::STAT_ANALOG_BIT]  = s.analog_en;
        v[bls_pkg::STAT_FILTER_BIT]  = s.filter_en;
        v[bls_pkg::STAT_HOLD_BIT]    = s.hold_en;
      end
      default: begin
        v = '0;
      end
    endcase
    read_mux = v;
  endfunction

  // Both pins come from the timing generator's domain and are synchronised first.
  bls_sync2 #(
    .WIDTH (2)
  ) u_pin_sync (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .async_in ({frame_sync_pin_in, external_clamp_enable_pin_in}),
    .sync_out (pins_sync)
  );

  assign ext_clamp_s = pins_sync[0];
  assign frame_s     = pins_sync[1];

  // The window generator times its pulse from the synchronised clamp pin.
  bls_clamp_pulse_gen #(
    .CNT_W (RW)
  ) u_pulse_gen (
    .clock_in       (clock_in),
    .rst_n_in       (rst_n_in),
    .clamp_sync_in  (ext_clamp_s),
    .pulse_delay_in (st_q.clamp_pulse_pixel_delay),
    .pulse_width_in (st_q.clamp_pulse_width),
    .pulse_out      (pulse)
  );

  // Steering decision, register port and all next-state logic.
  always_comb begin
    st_d       = st_q;
    frame_rise = frame_s & ~st_q.frame_prev;
    pulse_fall = st_q.pulse_prev & ~pulse;

    // Pulses are counted per frame until the start delay is reached.
    steer_ok = (st_q.pulse_cnt >= st_q.analog_steer_start_delay); // [RULE14]

    // Internal pulse may go to the analogue loop only when nothing holds it back.
    eligible = ~st_q.block_analog_steer                                   // [RULE3] [RULE4]
               & steer_ok                                                 // [RULE14]
               & (~st_q.loop_update_on_gain_write | st_q.gain_write_pending); // [RULE1] [RULE2]

    // The route is chosen at the pulse's first cycle and held for its whole width,
    // so a register write mid-window can cut an analogue correction short only through the source select bit or a pulse width below the current count.
    take_now = st_q.select_internal_clamp_source & pulse
               & (st_q.pulse_prev ? st_q.take : eligible);

    area_analog = area_term(st_q.area_define_usage, bls_pkg::AREA_ANALOG, area_define_in); // [RULE7] [RULE10]
    area_filter = area_term(st_q.area_define_usage, bls_pkg::AREA_FILTER, area_define_in); // [RULE7] [RULE11]

    // A pulse not taken by the analogue loop falls to the filter unless blocked.
    filter_now = (pulse & ~take_now & ~st_q.block_filter_steer) | area_filter; // [RULE4] [RULE5] [RULE6] [RULE11]

    // Analogue loop source is the pin or the steered internal pulse.
    st_d.analog_en = (st_q.select_internal_clamp_source ? take_now : ext_clamp_s) // [RULE12]
                     | area_analog;                                               // [RULE10]
    st_d.filter_en = filter_now;
    st_d.hold_en   = (st_q.area_define_usage == bls_pkg::AREA_HOLD) ? area_define_in // [RULE8]
                                                                    : filter_now;    // [RULE9]

    st_d.take       = take_now;
    st_d.pulse_prev = pulse;
    st_d.pulse_copy = pulse;
    st_d.frame_prev = frame_s;

    // Count ends of pulses, saturating at the start delay; a new frame restarts.
    if (frame_rise) begin
      st_d.pulse_cnt = '0; // [RULE14]
    end else if (pulse_fall && !steer_ok) begin
      st_d.pulse_cnt = st_q.pulse_cnt + RW'(1); // [RULE14]
    end

    // Pending clears after a delivered pulse; a gain write in the same cycle wins.
    if (pulse_fall && st_q.take) begin
      st_d.gain_write_pending = 1'b0; // [RULE15]
    end

    // Register writes.
    if (reg_write_in) begin
      unique case (reg_addr_in)
        bls_pkg::ADDR_CTRL: begin
          st_d.loop_update_on_gain_write    = reg_wdata_in[bls_pkg::CTRL_UPD_BIT];
          st_d.block_analog_steer           = reg_wdata_in[bls_pkg::CTRL_BLK_ANA_BIT];
          st_d.block_filter_steer           = reg_wdata_in[bls_pkg::CTRL_BLK_FIL_BIT];
          st_d.area_define_usage            =
            bls_pkg::bls_area_t'(reg_wdata_in[bls_pkg::CTRL_AREA_MSB:bls_pkg::CTRL_AREA_LSB]);
          st_d.select_internal_clamp_source = reg_wdata_in[bls_pkg::CTRL_SEL_INT_BIT];
        end
        bls_pkg::ADDR_STEER_DELAY: begin
          st_d.analog_steer_start_delay = reg_wdata_in[RW-1:0];
        end
        bls_pkg::ADDR_PULSE_DELAY: begin
          st_d.clamp_pulse_pixel_delay = reg_wdata_in[RW-1:0];
        end
        bls_pkg::ADDR_PULSE_WIDTH: begin
          st_d.clamp_pulse_width = reg_wdata_in[RW-1:0];
        end
        bls_pkg::ADDR_GAIN: begin
          st_d.gain               = reg_wdata_in[RW-1:0];
          st_d.gain_write_pending = 1'b1; // [RULE2]
        end
        default: begin
        end
      endcase
    end

    // Read data stand for exactly the cycle after the strobe.
    st_d.rdata = '0;
    if (reg_read_in) begin
      st_d.rdata = DATA_W'(read_mux(reg_addr_in, st_q, steer_ok));
    end
  end

  // Synchronous active-low reset loads the reset defaults.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      st_q                              <= '0;
      st_q.loop_update_on_gain_write    <= bls_pkg::CTRL_RST[bls_pkg::CTRL_UPD_BIT];
      st_q.block_analog_steer           <= bls_pkg::CTRL_RST[bls_pkg::CTRL_BLK_ANA_BIT];
      st_q.block_filter_steer           <= bls_pkg::CTRL_RST[bls_pkg::CTRL_BLK_FIL_BIT];
      st_q.area_define_usage            <= bls_pkg::AREA_OFF;
      st_q.select_internal_clamp_source <= bls_pkg::CTRL_RST[bls_pkg::CTRL_SEL_INT_BIT];
      st_q.analog_steer_start_delay     <= bls_pkg::STEER_DELAY_RST;
      st_q.clamp_pulse_pixel_delay      <= bls_pkg::PULSE_DELAY_RST;
      st_q.clamp_pulse_width            <= bls_pkg::PULSE_WIDTH_RST;
      st_q.gain                         <= bls_pkg::GAIN_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // Every output is a flip-flop of the state.
  assign reg_rdata_out                   = st_q.rdata;
  assign analog_loop_enable_out          = st_q.analog_en;
  assign filter_enable_out               = st_q.filter_en;
  assign error_hold_enable_out           = st_q.hold_en;
  assign internal_clamp_window_pulse_out = st_q.pulse_copy;

endmodule

// ### core/bls_sync2.sv
// Two-flop synchroniser for levels arriving from pins.
`timescale 1ns/1ps
module bls_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // Refuse a width that leaves nothing to synchronise.
  if (WIDTH < 1) begin : g_width_check
    $error("bls_sync2 needs WIDTH of at least one.");
  end

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } bls_sync_state_t;

  bls_sync_state_t st_d;
  bls_sync_state_t st_q;

  // The first stage feeds only the second, so metastability cannot spread.
  always_comb begin
    st_d        = st_q;
    st_d.stage1 = async_in;
    st_d.stage2 = st_q.stage1;
  end

  // Synchronous active-low reset clears both stages.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.stage2;

endmodule
